/* File: core/pmw_ctrl.sv */
// module: power mode switching, halt states, clock gating and wake-up
`timescale 1ns/1ps
module pmw_ctrl (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu core
  input wire logic halt_exec,
  input wire logic clr_wdt_exec,
  output logic cpu_stall,
  output logic resume_after_halt,
  output logic irq_vector_go,
  output logic pc_sp_reset,
  // watchdog
  input wire logic wdt_enabled,
  input wire logic wdt_overflow,
  output logic wdt_clear,
  output logic wdt_hold,
  output logic wdt_clk_en,
  // interrupts and port a
  input wire logic [7:0] irq_req,
  input wire logic [7:0] irq_enable,
  input wire logic stack_full,
  input wire logic [7:0] port_a_in,
  // oscillators
  input wire logic high_osc_stable,
  input wire logic low_clk_tick,
  output logic high_osc_enable,
  output logic low_osc_enable,
  // clock gating
  output logic sys_clk_en,
  output logic sys_src_low,
  output logic sys_tick,
  output logic tbc_clk_en,
  output logic [2:0] power_mode
);
  pmw_pkg::pmw_state_e state_r, state_nxt;
  pmw_pkg::pmw_cause_e cause_r, cause_nxt;
  logic [2:0] clock_divider_select_r;
  logic high_clock_select_r;
  logic idle_on_halt_enable_r;
  logic sysclk_in_idle_enable_r;
  logic [7:0] port_a_wake_enable_r;
  logic power_down_flag_r;
  logic watchdog_timeout_flag_r;
  logic low_osc_ready_r;
  logic high_osc_ready_r;
  logic [7:0] port_prev_r;
  logic [7:0] irq_armed_r;
  logic [5:0] div_cnt_r;
  logic resume_r, vector_r, pcsp_r, wclr_r;
  logic [31:0] rdata_nxt;

  // bus decode
  wire setup_ph = psel & ~penable;
  wire wr_acc = psel & penable & pwrite;
  wire hit_mode = (paddr == pmw_pkg::ADDR_MODE);
  wire hit_two = (paddr == pmw_pkg::ADDR_MODE_TWO);
  wire hit_wake = (paddr == pmw_pkg::ADDR_WAKE_EN);
  wire hit_stat = (paddr == pmw_pkg::ADDR_STATUS);
  wire hit_any = hit_mode | hit_two | hit_wake | hit_stat;

  // clock source selection
  wire div_is_slow = (clock_divider_select_r < pmw_pkg::DIV_SEL_FAST_MIN);
  wire src_low = ~high_clock_select_r & div_is_slow;
  wire [2:0] shift_amt = clock_divider_select_r - pmw_pkg::DIV_SEL_FAST_MIN;
  wire [5:0] div_mask = pmw_pkg::DIV_MASK_MAX >> shift_amt;
  wire hi_tick = high_clock_select_r | ((div_cnt_r & div_mask) == div_mask);
  wire src_ready = src_low ? low_osc_ready_r : high_osc_ready_r;

  // halt-state classification
  wire in_halt = (state_r == pmw_pkg::ST_DEEP_SLEEP) | (state_r == pmw_pkg::ST_WDOG_SLEEP)
               | (state_r == pmw_pkg::ST_IDLE_OFF) | (state_r == pmw_pkg::ST_IDLE_ON);
  wire in_idle = (state_r == pmw_pkg::ST_IDLE_OFF) | (state_r == pmw_pkg::ST_IDLE_ON);
  wire halt_go = (state_r == pmw_pkg::ST_RUN) & halt_exec;

  // wake sources
  wire [7:0] port_fall = port_prev_r & ~port_a_in & port_a_wake_enable_r;
  wire [7:0] irq_new = irq_req & irq_armed_r;
  wire wdt_wake = in_halt & wdt_overflow & ~wdt_hold;
  wire irq_wake = in_halt & (|irq_new);
  wire port_wake = in_halt & (|port_fall);
  wire any_wake = wdt_wake | irq_wake | port_wake;
  wire irq_can_vector = (|(irq_new & irq_enable)) & ~stack_full;

  always_comb begin
    state_nxt = state_r;
    cause_nxt = cause_r;
    case (state_r)
      pmw_pkg::ST_RUN: begin
        if (halt_exec) begin
          if (!idle_on_halt_enable_r) begin
            state_nxt = wdt_enabled ? pmw_pkg::ST_WDOG_SLEEP : pmw_pkg::ST_DEEP_SLEEP;
          end else begin
            state_nxt = sysclk_in_idle_enable_r ? pmw_pkg::ST_IDLE_ON : pmw_pkg::ST_IDLE_OFF;
          end
        end
      end
      pmw_pkg::ST_DEEP_SLEEP, pmw_pkg::ST_WDOG_SLEEP, pmw_pkg::ST_IDLE_OFF,
      pmw_pkg::ST_IDLE_ON: begin
        if (any_wake) begin
          state_nxt = pmw_pkg::ST_WAKE;
          if (wdt_wake) begin
            cause_nxt = pmw_pkg::WK_WDOG;
          end else if (irq_wake) begin
            cause_nxt = irq_can_vector ? pmw_pkg::WK_IRQ_VECTOR : pmw_pkg::WK_IRQ_RESUME;
          end else begin
            cause_nxt = pmw_pkg::WK_PORT;
          end
        end
      end
      pmw_pkg::ST_WAKE: begin
        if (src_ready) begin
          state_nxt = pmw_pkg::ST_RUN;
        end
      end
      default: state_nxt = pmw_pkg::ST_RUN;
    endcase
  end

  wire wake_done = (state_r == pmw_pkg::ST_WAKE) & src_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= pmw_pkg::ST_RUN;
      cause_r <= pmw_pkg::WK_PORT;
      resume_r <= 1'b0;
      vector_r <= 1'b0;
      pcsp_r <= 1'b0;
      wclr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cause_r <= cause_nxt;
      resume_r <= wake_done & ((cause_r == pmw_pkg::WK_PORT)
                             | (cause_r == pmw_pkg::WK_IRQ_RESUME));
      vector_r <= wake_done & (cause_r == pmw_pkg::WK_IRQ_VECTOR);
      pcsp_r <= wake_done & (cause_r == pmw_pkg::WK_WDOG);
      wclr_r <= halt_go;
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_divider_select_r <= pmw_pkg::RST_DIV_SEL;
      high_clock_select_r <= pmw_pkg::RST_HCS;
      idle_on_halt_enable_r <= pmw_pkg::RST_IDLE_EN;
      sysclk_in_idle_enable_r <= pmw_pkg::RST_SYSON;
      port_a_wake_enable_r <= pmw_pkg::RST_WAKE_EN;
    end else if (wr_acc) begin
      if (hit_mode) begin
        clock_divider_select_r <= pwdata[pmw_pkg::MODE_DIV_LSB +: 3];
        high_clock_select_r <= pwdata[pmw_pkg::MODE_HCS_BIT];
        idle_on_halt_enable_r <= pwdata[pmw_pkg::MODE_IDLE_BIT];
      end
      if (hit_two) begin
        sysclk_in_idle_enable_r <= pwdata[pmw_pkg::MODE_TWO_SYSON_BIT];
      end
      if (hit_wake) begin
        port_a_wake_enable_r <= pwdata[7:0];
      end
    end
  end

  // status flags; a set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_down_flag_r <= 1'b0;
      watchdog_timeout_flag_r <= 1'b0;
    end else begin
      if (halt_go) begin
        power_down_flag_r <= 1'b1;
      end else if (clr_wdt_exec) begin
        power_down_flag_r <= 1'b0;
      end
      if (wdt_wake) begin
        watchdog_timeout_flag_r <= 1'b1;
      end else if (halt_go) begin
        watchdog_timeout_flag_r <= 1'b0;
      end
    end
  end

  // oscillator ready, edge history, interrupt arming, divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_osc_ready_r <= 1'b0;
      high_osc_ready_r <= 1'b0;
      port_prev_r <= 8'h00;
      irq_armed_r <= 8'h00;
      div_cnt_r <= 6'h00;
    end else begin
      if (state_nxt == pmw_pkg::ST_DEEP_SLEEP) begin
        low_osc_ready_r <= 1'b0;
      end else if (low_clk_tick) begin
        low_osc_ready_r <= 1'b1;
      end
      high_osc_ready_r <= high_osc_stable & high_osc_enable;
      port_prev_r <= port_a_in;
      if (halt_go) begin
        irq_armed_r <= ~irq_req;
      end
      div_cnt_r <= div_cnt_r + 6'h01;
    end
  end

  // register read data, taken at the setup cycle
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit_mode) begin
      rdata_nxt[pmw_pkg::MODE_DIV_LSB +: 3] = clock_divider_select_r;
      rdata_nxt[pmw_pkg::MODE_LRDY_BIT] = low_osc_ready_r;
      rdata_nxt[pmw_pkg::MODE_HRDY_BIT] = high_osc_ready_r;
      rdata_nxt[pmw_pkg::MODE_IDLE_BIT] = idle_on_halt_enable_r;
      rdata_nxt[pmw_pkg::MODE_HCS_BIT] = high_clock_select_r;
    end else if (hit_two) begin
      rdata_nxt[pmw_pkg::MODE_TWO_SYSON_BIT] = sysclk_in_idle_enable_r;
    end else if (hit_wake) begin
      rdata_nxt[7:0] = port_a_wake_enable_r;
    end else if (hit_stat) begin
      rdata_nxt[pmw_pkg::STAT_PDF_BIT] = power_down_flag_r;
      rdata_nxt[pmw_pkg::STAT_TO_BIT] = watchdog_timeout_flag_r;
      rdata_nxt[pmw_pkg::STAT_STATE_LSB +: 3] = state_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata <= rdata_nxt;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // clock gating and cpu outputs
  wire deep = (state_r == pmw_pkg::ST_DEEP_SLEEP);
  assign sys_src_low = src_low;
  assign sys_clk_en = (state_r == pmw_pkg::ST_RUN) | (state_r == pmw_pkg::ST_IDLE_ON)
                    | (state_r == pmw_pkg::ST_WAKE);
  assign tbc_clk_en = sys_clk_en | (state_r == pmw_pkg::ST_IDLE_OFF);
  assign sys_tick = sys_clk_en & (src_low ? low_clk_tick : hi_tick);
  assign high_osc_enable = ~src_low & sys_clk_en;
  assign low_osc_enable = ~deep;
  assign wdt_clk_en = ~deep;
  assign wdt_hold = deep | (in_idle & ~wdt_enabled);
  assign wdt_clear = wclr_r;
  assign cpu_stall = (state_r != pmw_pkg::ST_RUN);
  assign resume_after_halt = resume_r;
  assign irq_vector_go = vector_r;
  assign pc_sp_reset = pcsp_r;
  assign power_mode = state_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_slow_src;
    (!high_clock_select_r && clock_divider_select_r <= 3'h1) |-> sys_src_low && !high_osc_enable;
  endproperty
  a_slow_src: assert property (p_slow_src) else $error("slow select not honoured");

  property p_fast_src;
    (high_clock_select_r || clock_divider_select_r[2:1] != 2'b00) |-> !sys_src_low;
  endproperty
  a_fast_src: assert property (p_fast_src) else $error("fast select not honoured");

  property p_div_tick;
    (state_r == pmw_pkg::ST_RUN && !high_clock_select_r && clock_divider_select_r == 3'h7
     && sys_tick && !(wr_acc && hit_mode)) |=> !sys_tick;
  endproperty
  a_div_tick: assert property (p_div_tick) else $error("half-rate tick wrong");

  property p_deep;
    halt_go && !idle_on_halt_enable_r && !wdt_enabled |=>
      deep && !sys_clk_en && !wdt_clk_en && !tbc_clk_en && wdt_hold && !low_osc_ready_r;
  endproperty
  a_deep: assert property (p_deep) else $error("deep sleep clocks wrong");

  property p_wdsleep;
    halt_go && !idle_on_halt_enable_r && wdt_enabled |=>
      wdt_clk_en && !sys_clk_en && !tbc_clk_en && !wdt_hold;
  endproperty
  a_wdsleep: assert property (p_wdsleep) else $error("watchdog sleep clocks wrong");

  property p_idle_on;
    halt_go && idle_on_halt_enable_r && sysclk_in_idle_enable_r |=>
      sys_clk_en && tbc_clk_en && cpu_stall;
  endproperty
  a_idle_on: assert property (p_idle_on) else $error("clock-on idle wrong");

  property p_halt_flags;
    halt_go && !wdt_wake |=> power_down_flag_r && !watchdog_timeout_flag_r && wdt_clear;
  endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt entry flags wrong");

  property p_wdt_wake;
    wdt_wake |=> watchdog_timeout_flag_r && state_r == pmw_pkg::ST_WAKE;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake not flagged");

  property p_hold_stall;
    state_r == pmw_pkg::ST_WAKE && !src_ready |=> cpu_stall && !resume_after_halt;
  endproperty
  a_hold_stall: assert property (p_hold_stall) else $error("cpu released early");

  property p_idle_off;
    halt_go && idle_on_halt_enable_r && !sysclk_in_idle_enable_r |=>
      !sys_clk_en && tbc_clk_en && cpu_stall;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("clock-off idle wrong");

  property p_slow_stop;
    sys_src_low |-> !high_osc_enable;
  endproperty
  a_slow_stop: assert property (p_slow_stop) else $error("fast osc left running");

  property p_pdf_clear;
    clr_wdt_exec && !halt_go |=> !power_down_flag_r;
  endproperty
  a_pdf_clear: assert property (p_pdf_clear) else $error("power-down flag not cleared");

  property p_port_wake;
    port_wake && !wdt_wake && !irq_wake |=>
      state_r == pmw_pkg::ST_WAKE && cause_r == pmw_pkg::WK_PORT;
  endproperty
  a_port_wake: assert property (p_port_wake) else $error("port wake not taken");

  property p_irq_vector;
    irq_wake && !wdt_wake && irq_can_vector |=> cause_r == pmw_pkg::WK_IRQ_VECTOR;
  endproperty
  a_irq_vector: assert property (p_irq_vector) else $error("vectoring wake lost");

  property p_irq_arm;
    halt_go |=> irq_armed_r == ~$past(irq_req);
  endproperty
  a_irq_arm: assert property (p_irq_arm) else $error("pending irq still armed");
endmodule

/* File: core/pmw_pkg.sv */
// package: constants for the power mode and wake-up controller
package pmw_pkg;
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_MODE_TWO = 8'h04;
  localparam logic [7:0] ADDR_WAKE_EN = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam int MODE_DIV_LSB = 5;
  localparam int MODE_LRDY_BIT = 3;
  localparam int MODE_HRDY_BIT = 2;
  localparam int MODE_IDLE_BIT = 1;
  localparam int MODE_HCS_BIT = 0;
  localparam int MODE_TWO_SYSON_BIT = 7;
  localparam int STAT_PDF_BIT = 0;
  localparam int STAT_TO_BIT = 1;
  localparam int STAT_STATE_LSB = 4;
  localparam logic [2:0] RST_DIV_SEL = 3'h0;
  localparam logic RST_IDLE_EN = 1'b1;
  localparam logic RST_HCS = 1'b1;
  localparam logic RST_SYSON = 1'b0;
  localparam logic [7:0] RST_WAKE_EN = 8'h00;
  localparam logic [2:0] DIV_SEL_FAST_MIN = 3'h2;
  localparam logic [5:0] DIV_MASK_MAX = 6'h3F;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_DEEP_SLEEP = 3'b001,
    ST_WDOG_SLEEP = 3'b010,
    ST_IDLE_OFF = 3'b011,
    ST_IDLE_ON = 3'b100,
    ST_WAKE = 3'b101
  } pmw_state_e;
  typedef enum logic [1:0] {
    WK_PORT = 2'b00,
    WK_IRQ_RESUME = 2'b01,
    WK_IRQ_VECTOR = 2'b10,
    WK_WDOG = 2'b11
  } pmw_cause_e;
endpackage

/* File: testbench/pmw_far_model.sv */
// far-side model: fast oscillator settling and slow clock ticks
`timescale 1ns/1ps
module pmw_far_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // oscillator enables
  input wire logic high_osc_enable,
  input wire logic low_osc_enable,
  // oscillator status
  output logic high_osc_stable,
  output logic low_clk_tick
);
  logic [2:0] hcnt_r;
  logic [2:0] lcnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hcnt_r <= 3'h0;
      lcnt_r <= 3'h0;
    end else begin
      hcnt_r <= !high_osc_enable ? 3'h0 : (hcnt_r == 3'h7 ? hcnt_r : hcnt_r + 3'h1);
      lcnt_r <= low_osc_enable ? lcnt_r + 3'h1 : 3'h0;
    end
  end
  // stable only after a settling run, drops at the first clock edge after it is disabled
  assign high_osc_stable = hcnt_r == 3'h7;
  assign low_clk_tick = low_osc_enable && lcnt_r == 3'h7;
endmodule

/* File: testbench/tb.sv */
// testbench: power mode and wake-up controller
`timescale 1ns/1ps
module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic halt_exec = 1'b0, clr_wdt_exec = 1'b0, wdt_enabled = 1'b0, wdt_overflow = 1'b0;
  logic stack_full = 1'b0;
  logic [7:0] paddr = 8'h00, irq_req = 8'h00, irq_enable = 8'h00, port_a_in = 8'hFF;
  logic [31:0] pwdata = 32'h0000_0000, prdata, lfsr = 32'h0000_bc1a;
  logic pready, pslverr, cpu_stall, resume_after_halt, irq_vector_go, pc_sp_reset;
  logic wdt_clear, wdt_hold, wdt_clk_en, high_osc_stable, low_clk_tick;
  logic high_osc_enable, low_osc_enable, sys_clk_en, sys_src_low, sys_tick, tbc_clk_en;
  logic [2:0] power_mode;
  logic [32:0] expq[$];
  logic [4:0] lv [4] = '{5'h03, 5'h05, 5'h0F, 5'h1F};
  logic [2:0] wk [4] = '{3'h4, 3'h1, 3'h2, 3'h4};
  int errors = 0, num_checks = 0, cyc = 0;
  always #25 pclk = ~pclk;
  pmw_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .halt_exec, .clr_wdt_exec, .cpu_stall, .resume_after_halt,
    .irq_vector_go, .pc_sp_reset, .wdt_enabled, .wdt_overflow, .wdt_clear, .wdt_hold,
    .wdt_clk_en, .irq_req, .irq_enable, .stack_full, .port_a_in, .high_osc_stable,
    .low_clk_tick, .high_osc_enable, .low_osc_enable, .sys_clk_en, .sys_src_low,
    .sys_tick, .tbc_clk_en, .power_mode);
  pmw_far_model u_far (.pclk, .presetn, .high_osc_enable, .low_osc_enable,
    .high_osc_stable, .low_clk_tick);
  function automatic logic [31:0] nxt_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic fail(input string m);
    errors++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    num_checks++;
    if (g !== e) fail($sformatf("got %h want %h", g, e));
  endtask
  task automatic cmp(input logic [32:0] g);
    chk(g, expq.size() > 0 ? expq.pop_front() : {33{1'bx}});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic pulse_in(input bit clr);
    @(posedge pclk);
    if (clr) clr_wdt_exec <= 1'b1;
    else halt_exec <= 1'b1;
    @(posedge pclk);
    clr_wdt_exec <= 1'b0;
    halt_exec <= 1'b0;
  endtask
  // results as they appear, matched against the oldest note
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail("timeout");
      tally_and_finish;
    end
    if (presetn && psel && penable && pready && !pwrite) cmp({pslverr, prdata});
    if (resume_after_halt || irq_vector_go || pc_sp_reset)
      cmp({30'h0000_0000, resume_after_halt, irq_vector_go, pc_sp_reset});
  end
  initial begin
    int n;
    int cnt;
    logic [2:0] k;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
    rd(8'h00, 33'h0_0000_000F);
    rd(8'h0C, 33'h0_0000_0000);
    rd(8'h10, 33'h1_0000_0000);
    lfsr = nxt_rand(lfsr);
    k = lfsr[2:0];
    apb(1'b1, 8'h08, 32'(8'h01 << k));
    rd(8'h08, 33'(8'h01 << k));
    for (n = 0; n < 9; n++) begin
      apb(1'b1, 8'h00, n == 8 ? 32'h0000_0003 : {24'h00_0000, 3'(n), 5'h02});
      repeat (20) @(posedge pclk);
      cnt = 0;
      repeat (128) begin
        @(posedge pclk);
        #1 cnt += int'(sys_tick);
      end
      chk(33'(cnt), n == 8 ? 33'h80 : (n < 2 ? 33'h10 : 33'(1 << (n - 1))));
      chk(33'({sys_src_low, high_osc_enable}), n < 2 ? 33'h2 : 33'h1);
    end
    for (n = 0; n < 4; n++) begin
      apb(1'b1, 8'h00, n < 2 ? 32'h0000_0001 : 32'h0000_0003);
      apb(1'b1, 8'h04, n == 3 ? 32'h0000_0080 : 32'h0000_0000);
      wdt_enabled <= n == 1;
      irq_enable <= n == 3 ? 8'h00 : 8'hFF;
      irq_req <= 8'h02;
      pulse_in(1'b0);
      #1 chk(33'(wdt_clear), 33'h1);
      chk(33'({sys_clk_en, tbc_clk_en, wdt_clk_en, wdt_hold, cpu_stall}), 33'(lv[n]));
      chk(33'({power_mode, low_osc_enable}), 33'({3'(n + 1), n != 0}));
      repeat (5) @(posedge pclk);
      rd(8'h0C, 33'({3'(n + 1), 4'h1}));
      if (n == 0) rd(8'h00, 33'h0_0000_0001);
      expq.push_back(33'(wk[n]));
      @(posedge pclk);
      port_a_in <= n == 0 ? ~(8'h01 << k) : 8'hFF;
      wdt_overflow <= n == 1;
      irq_req <= n > 1 ? 8'h03 : 8'h02;
      @(posedge pclk);
      wdt_overflow <= 1'b0;
      port_a_in <= 8'hFF;
      while (cpu_stall !== 1'b0) @(posedge pclk);
      irq_req <= 8'h00;
      repeat (20) @(posedge pclk);
      rd(8'h00, n < 2 ? 33'h0_0000_000D : 33'h0_0000_000F);
      rd(8'h0C, n == 1 ? 33'h0_0000_0003 : 33'h0_0000_0001);
      if (n == 1) begin
        pulse_in(1'b1);
        rd(8'h0C, 33'h0_0000_0002);
      end
    end
    repeat (4) @(posedge pclk);
    tally_and_finish;
  end
endmodule
